// File: sweep_seq_regs.svh
`ifndef SWEEP_SEQ_REGS_SVH
`define SWEEP_SEQ_REGS_SVH
// register word offsets
`define REG_CTRL 4'h0
`define REG_START_F 4'h1
`define REG_STOP_F 4'h2
`define REG_CENTER_F 4'h3
`define REG_SPAN_F 4'h4
`define REG_START_P 4'h5
`define REG_STOP_P 4'h6
`define REG_OFFSET 4'h7
`define REG_DWELL 4'h8
`define REG_STEP_COUNT 4'h9
`define REG_MANUAL 4'hA
`define REG_CMD 4'hB
`define REG_STATUS 4'hC
`define REG_CUR_F 4'hD
`define REG_CUR_P 4'hE
// control fields
`define CTRL_ENABLE 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 3
`define CTRL_RUNMODE_LSB 4
`define CTRL_RUNMODE_MSB 5
`define CTRL_RETRACE 6
`define CTRL_SAWTOOTH 7
`define CTRL_REVERSE 8
`define CTRL_REMOTE 9
// command fields (write only, self clearing)
`define CMD_RESET 0
`define CMD_TRIG 1
`define CMD_STEP 2
// reset values
`define DWELL_RESET 32'h0000_0032
`define STEP_COUNT_RESET 16'h000A
`endif

// File: sweep_seq_pkg.sv
package sweep_seq_pkg;
	// trigger mode selects which events move the sequencer
	typedef enum logic [2:0] {
		TRIG_AUTO = 3'h0,
		TRIG_SINGLE = 3'h1,
		TRIG_EXT_SINGLE = 3'h2,
		TRIG_EXT_TOGGLE = 3'h3,
		TRIG_MANUAL = 3'h4
	} trig_mode_type;
	// cycle handling: one cycle, continuous, or one step per event
	typedef enum logic [1:0] {
		RUN_SINGLE = 2'h0,
		RUN_CONT = 2'h1,
		RUN_STEP = 2'h2
	} run_mode_type;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HOLD = 4'b0010,
		ST_RUN = 4'b0100,
		ST_DONE = 4'b1000
	} seq_state_type;
endpackage

// File: sweep_trigger_sequencer.sv
`timescale 1ns/1ns
`include "sweep_seq_regs.svh"
module sweep_trigger_sequencer #(
	parameter int W = 32,
	parameter int PW = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ext_trig,
	output logic [W-1:0] out_freq,
	output logic [W-1:0] out_level,
	output logic out_update,
	output logic running
);
	logic enable_q, retrace_q, sawtooth_q, reverse_q, remote_q;
	sweep_seq_pkg::trig_mode_type mode_q;
	sweep_seq_pkg::run_mode_type run_q;
	logic signed [W-1:0] start_f_q, stop_f_q, start_p_q, stop_p_q, offset_q;
	logic [W-1:0] dwell_q;
	logic [PW-1:0] step_count_q, index_q;
	logic signed [W-1:0] cur_f_q, cur_p_q;
	sweep_seq_pkg::seq_state_type state_q;
	logic [W-1:0] dwell_cnt_q;
	logic sync1_q, sync2_q, sync3_q;
	logic trig_pulse, sw_trig, step_cmd, rst_cmd, mode_chg, load_start, advance;
	logic at_end, dwell_done, wr_ctrl, retrace_ok, halted_q;
	logic signed [W-1:0] step_f, step_p, span_f, center_f;

	function automatic logic signed [W-1:0] half_of(input logic signed [W-1:0] v);
		half_of = v >>> 1;
	endfunction

	// linear step: span divided over step_count-1 intervals
	function automatic logic signed [W-1:0] lin_step(input logic signed [W-1:0] a,
		input logic signed [W-1:0] b, input logic [PW-1:0] n);
		logic signed [W-1:0] den;
		den = (n > 16'h0001) ? W'(signed'({1'b0, n}) - 1) : W'(1);
		lin_step = (b - a) / den;
	endfunction

	assign span_f = stop_f_q - start_f_q;
	assign center_f = half_of(start_f_q + stop_f_q);
	assign step_f = lin_step(start_f_q, stop_f_q, step_count_q);
	assign step_p = lin_step(start_p_q, stop_p_q, step_count_q);

	// three flops: two to synchronise, the third only for the edge detector
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else if (clk_en) begin
			sync1_q <= ext_trig;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign trig_pulse = sync2_q & ~sync3_q;

	assign wr_ctrl = clk_en & reg_wr & (reg_addr == `REG_CTRL);
	assign mode_chg = wr_ctrl &&
		(reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != mode_q);
	assign sw_trig = clk_en & reg_wr & (reg_addr == `REG_CMD) & reg_wdata[`CMD_TRIG];
	assign step_cmd = clk_en & reg_wr & (reg_addr == `REG_CMD) & reg_wdata[`CMD_STEP];
	assign rst_cmd = clk_en & reg_wr & (reg_addr == `REG_CMD) & reg_wdata[`CMD_RESET];
	// retrace is honoured only for single modes with sawtooth shape
	assign retrace_ok = retrace_q & sawtooth_q & ((mode_q == sweep_seq_pkg::TRIG_SINGLE) |
		(mode_q == sweep_seq_pkg::TRIG_EXT_SINGLE));

	// register file
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= 1'b0;
			mode_q <= sweep_seq_pkg::TRIG_AUTO;
			run_q <= sweep_seq_pkg::RUN_CONT;
			retrace_q <= 1'b0;
			sawtooth_q <= 1'b1;
			reverse_q <= 1'b0;
			remote_q <= 1'b0;
			start_f_q <= '0;
			stop_f_q <= '0;
			start_p_q <= '0;
			stop_p_q <= '0;
			offset_q <= '0;
			dwell_q <= `DWELL_RESET;
			step_count_q <= `STEP_COUNT_RESET;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`REG_CTRL: begin
					enable_q <= reg_wdata[`CTRL_ENABLE];
					remote_q <= reg_wdata[`CTRL_REMOTE];
					// local panel cannot pick manual mode; keep the old mode
					if (reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] !=
						sweep_seq_pkg::TRIG_MANUAL || reg_wdata[`CTRL_REMOTE]) begin
						mode_q <= sweep_seq_pkg::trig_mode_type'(
							reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
					end
					run_q <= sweep_seq_pkg::run_mode_type'(
						reg_wdata[`CTRL_RUNMODE_MSB:`CTRL_RUNMODE_LSB]);
					retrace_q <= reg_wdata[`CTRL_RETRACE];
					sawtooth_q <= reg_wdata[`CTRL_SAWTOOTH];
					reverse_q <= reg_wdata[`CTRL_REVERSE];
				end
				`REG_START_F: start_f_q <= W'(reg_wdata);
				`REG_STOP_F: stop_f_q <= W'(reg_wdata);
				`REG_CENTER_F: begin
					start_f_q <= W'(reg_wdata) - half_of(span_f);
					stop_f_q <= W'(reg_wdata) + (span_f - half_of(span_f));
				end
				`REG_SPAN_F: begin
					start_f_q <= center_f - half_of(W'(reg_wdata));
					stop_f_q <= center_f + (W'(reg_wdata) - half_of(W'(reg_wdata)));
				end
				`REG_START_P: start_p_q <= W'(reg_wdata);
				`REG_STOP_P: stop_p_q <= W'(reg_wdata);
				`REG_OFFSET: offset_q <= W'(reg_wdata);
				`REG_DWELL: dwell_q <= W'(reg_wdata);
				`REG_STEP_COUNT: step_count_q <= reg_wdata[PW-1:0];
				default: begin
				end
			endcase
		end
	end

	assign at_end = reverse_q ? (index_q == '0) : (index_q >= step_count_q - 16'h0001);
	assign dwell_done = (dwell_cnt_q + 32'h1 >= dwell_q);

	// sequencer states: idle (off), hold (waiting at start), run, done (at end)
	always_comb begin
		// a sweep reset, or a trigger out of done, must reload the start value
		load_start = rst_cmd;
		advance = 1'b0;
		if (state_q == sweep_seq_pkg::ST_DONE) begin
			case (mode_q)
				sweep_seq_pkg::TRIG_SINGLE: begin
					load_start = rst_cmd | sw_trig | trig_pulse;
				end
				sweep_seq_pkg::TRIG_EXT_SINGLE, sweep_seq_pkg::TRIG_EXT_TOGGLE: begin
					load_start = rst_cmd | trig_pulse;
				end
				default: load_start = rst_cmd;
			endcase
		end
		if (state_q == sweep_seq_pkg::ST_RUN) begin
			if (run_q == sweep_seq_pkg::RUN_STEP) begin
				advance = step_cmd | trig_pulse;
			end else begin
				advance = dwell_done;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= sweep_seq_pkg::ST_IDLE;
			halted_q <= 1'b0;
		end else if (clk_en) begin
			if (!enable_q || (wr_ctrl && !reg_wdata[`CTRL_ENABLE])) begin
				state_q <= sweep_seq_pkg::ST_IDLE;
				halted_q <= 1'b0;
			end else if (mode_chg) begin
				state_q <= sweep_seq_pkg::ST_HOLD;
			end else if (rst_cmd) begin
				state_q <= (mode_q == sweep_seq_pkg::TRIG_AUTO ||
					mode_q == sweep_seq_pkg::TRIG_MANUAL) ?
					sweep_seq_pkg::ST_RUN : sweep_seq_pkg::ST_HOLD;
			end else begin
				case (state_q)
					sweep_seq_pkg::ST_IDLE: begin
						state_q <= (mode_q == sweep_seq_pkg::TRIG_AUTO ||
							mode_q == sweep_seq_pkg::TRIG_MANUAL) ?
							sweep_seq_pkg::ST_RUN : sweep_seq_pkg::ST_HOLD;
					end
					sweep_seq_pkg::ST_HOLD, sweep_seq_pkg::ST_DONE: begin
						case (mode_q)
							sweep_seq_pkg::TRIG_EXT_TOGGLE: if (trig_pulse) begin
								state_q <= sweep_seq_pkg::ST_RUN;
								halted_q <= 1'b0;
							end
							sweep_seq_pkg::TRIG_SINGLE: if (sw_trig | trig_pulse) begin
								state_q <= sweep_seq_pkg::ST_RUN;
							end
							sweep_seq_pkg::TRIG_EXT_SINGLE: if (trig_pulse) begin
								state_q <= sweep_seq_pkg::ST_RUN;
							end
							default: state_q <= sweep_seq_pkg::ST_RUN;
						endcase
					end
					sweep_seq_pkg::ST_RUN: begin
						if (mode_q == sweep_seq_pkg::TRIG_EXT_TOGGLE && trig_pulse) begin
							state_q <= sweep_seq_pkg::ST_HOLD;
							halted_q <= 1'b1;
						end else if (mode_q == sweep_seq_pkg::TRIG_MANUAL) begin
							state_q <= sweep_seq_pkg::ST_RUN;
						end else if (advance && at_end && (run_q == sweep_seq_pkg::RUN_SINGLE ||
							mode_q == sweep_seq_pkg::TRIG_SINGLE ||
							mode_q == sweep_seq_pkg::TRIG_EXT_SINGLE)) begin
							state_q <= sweep_seq_pkg::ST_DONE;
						end
					end
					default: state_q <= sweep_seq_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// step index and output values
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			index_q <= '0;
			cur_f_q <= '0;
			cur_p_q <= '0;
			out_update <= 1'b0;
		end else if (clk_en) begin
			out_update <= 1'b0;
			if (load_start || (state_q != sweep_seq_pkg::ST_RUN &&
				state_q != sweep_seq_pkg::ST_DONE)) begin
				// hold the start value (or the end when reversed) in idle and hold
				index_q <= reverse_q ? step_count_q - 16'h0001 : '0;
				cur_f_q <= reverse_q ? stop_f_q : start_f_q;
				cur_p_q <= reverse_q ? stop_p_q : start_p_q;
			end else if (mode_q == sweep_seq_pkg::TRIG_MANUAL &&
				clk_en && reg_wr && reg_addr == `REG_MANUAL) begin
				cur_f_q <= W'(reg_wdata);
				out_update <= 1'b1;
			end else if (advance && mode_q != sweep_seq_pkg::TRIG_MANUAL) begin
				out_update <= 1'b1;
				if (at_end) begin
					// wrap, or retrace to start at the end of a single cycle
					index_q <= reverse_q ? step_count_q - 16'h0001 : '0;
					cur_f_q <= reverse_q ? stop_f_q : start_f_q;
					cur_p_q <= reverse_q ? stop_p_q : start_p_q;
					if (state_q == sweep_seq_pkg::ST_RUN && !retrace_ok &&
						(run_q == sweep_seq_pkg::RUN_SINGLE ||
						mode_q == sweep_seq_pkg::TRIG_SINGLE ||
						mode_q == sweep_seq_pkg::TRIG_EXT_SINGLE)) begin
						cur_f_q <= cur_f_q;
						cur_p_q <= cur_p_q;
						index_q <= index_q;
					end
				end else if (reverse_q) begin
					index_q <= index_q - 16'h0001;
					cur_f_q <= cur_f_q - step_f;
					cur_p_q <= cur_p_q - step_p;
				end else begin
					index_q <= index_q + 16'h0001;
					cur_f_q <= cur_f_q + step_f;
					cur_p_q <= cur_p_q + step_p;
				end
			end
		end
	end

	// dwell timer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dwell_cnt_q <= '0;
		end else if (clk_en) begin
			if (state_q != sweep_seq_pkg::ST_RUN || advance || load_start) begin
				dwell_cnt_q <= '0;
			end else begin
				dwell_cnt_q <= dwell_cnt_q + 32'h1;
			end
		end
	end

	assign out_freq = cur_f_q + offset_q;
	assign out_level = cur_p_q;
	assign running = (state_q == sweep_seq_pkg::ST_RUN);

	// read port, data valid the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				case (reg_addr)
					`REG_CTRL: reg_rdata <= {22'h0, remote_q, reverse_q, sawtooth_q, retrace_q,
						run_q, mode_q, enable_q};
					`REG_START_F: reg_rdata <= start_f_q + offset_q;
					`REG_STOP_F: reg_rdata <= stop_f_q + offset_q;
					`REG_CENTER_F: reg_rdata <= center_f + offset_q;
					`REG_SPAN_F: reg_rdata <= span_f;
					`REG_START_P: reg_rdata <= start_p_q;
					`REG_STOP_P: reg_rdata <= stop_p_q;
					`REG_OFFSET: reg_rdata <= offset_q;
					`REG_DWELL: reg_rdata <= dwell_q;
					`REG_STEP_COUNT: reg_rdata <= {16'h0, step_count_q};
					`REG_STATUS: reg_rdata <= {12'h0, index_q, halted_q, state_q[2:0]};
					`REG_CUR_F: reg_rdata <= out_freq;
					`REG_CUR_P: reg_rdata <= cur_p_q;
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	a_disable_stops: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && !enable_q |=> !running) else $error("sweep runs while disabled");
	a_toggle_halt: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && enable_q && running && mode_q == sweep_seq_pkg::TRIG_EXT_TOGGLE &&
		trig_pulse && !mode_chg && !rst_cmd && !wr_ctrl |=> !running)
		else $error("toggle trigger did not halt");
	a_trig_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && trig_pulse |=> !trig_pulse) else $error("trigger pulse longer than one cycle");
	a_hold_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && state_q == sweep_seq_pkg::ST_HOLD && !reverse_q && $stable(start_f_q)
		&& $past(clk_en) && $past(state_q) == sweep_seq_pkg::ST_HOLD |-> cur_f_q == start_f_q)
		else $error("hold state not at start value");
	a_dwell_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && advance |=> dwell_cnt_q == '0) else $error("dwell not restarted");
	a_mode_change: assert property (@(posedge core_clk) disable iff (!arst_n)
		mode_chg && enable_q && reg_wdata[`CTRL_ENABLE] |=> !running)
		else $error("mode change did not stop sweep");
	a_local_manual: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_ctrl && !reg_wdata[`CTRL_REMOTE] && mode_q != sweep_seq_pkg::TRIG_MANUAL |=>
		mode_q != sweep_seq_pkg::TRIG_MANUAL) else $error("manual mode from local");
	a_step_add: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && advance && !at_end && !reverse_q && mode_q != sweep_seq_pkg::TRIG_MANUAL
		&& !load_start && !(reg_wr && reg_addr == `REG_MANUAL) |=>
		cur_f_q == $past(cur_f_q) + $past(step_f))
		else $error("linear step not added");
	a_reset_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && enable_q && rst_cmd && !reverse_q |=> cur_f_q == $past(start_f_q) && index_q == '0)
		else $error("sweep reset did not return to start");
	a_single_stop: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && running && advance && at_end && !load_start && !retrace_ok &&
		mode_q == sweep_seq_pkg::TRIG_SINGLE |=> !running && $stable(cur_f_q))
		else $error("single sweep did not stop at end value");
	a_freeze_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		!clk_en |=> $stable(state_q) && $stable(cur_f_q) && $stable(dwell_cnt_q))
		else $error("state moved while clock enable low");
	c_toggle_run: cover property (@(posedge core_clk) mode_q == sweep_seq_pkg::TRIG_EXT_TOGGLE
		&& running && trig_pulse);
	c_wrap: cover property (@(posedge core_clk) running && advance && at_end);
	c_retrace: cover property (@(posedge core_clk) retrace_ok && advance && at_end);
	c_single_done: cover property (@(posedge core_clk) state_q == sweep_seq_pkg::ST_DONE && load_start);
	c_sweep_reset: cover property (@(posedge core_clk) running && rst_cmd);
endmodule

// File: trig_source.sv
`timescale 1ns/1ns
// external trigger source; the line is always driven and idles low
module trig_source (
	input wire logic core_clk,
	output logic ext_trig
);
	initial ext_trig = 1'b0;
	// low for a few cycles first so the synchroniser sees a clean rising edge
	task automatic fire(input int hold);
		repeat (3) @(posedge core_clk);
		ext_trig <= 1'b1;
		repeat (hold) @(posedge core_clk);
		ext_trig <= 1'b0;
	endtask
endmodule

// File: sweep_trigger_sequencer_tb.sv
`timescale 1ns/1ns
`include "sweep_seq_regs.svh"
module sweep_trigger_sequencer_tb;
	localparam int DW = 4;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic ext_trig;
	logic [31:0] out_freq;
	logic [31:0] out_level;
	logic out_update;
	logic running;
	int err_total = 0;
	int total_checks = 0;
	int seed = int'(32'hED19C41C);
	int cyc = 0;
	logic [31:0] rd_val, a, b;
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;
	sweep_trigger_sequencer #(.W(32), .PW(16)) i_dut (
		.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_trig(ext_trig), .out_freq(out_freq), .out_level(out_level),
		.out_update(out_update), .running(running));
	trig_source i_trig (.core_clk(core_clk), .ext_trig(ext_trig));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] r,
		input int en, input int ret, input int rev, input int rem);
		return {22'h0, rem[0], rev[0], 1'b1, ret[0], r, m, en[0]};
	endfunction
	task automatic wait_run(input logic v);
		int w;
		w = 0;
		#1;
		while (running !== v && w < 30) begin
			@(posedge core_clk);
			#1 w++;
		end
		chk("running", 32'(v), 32'(running));
	endtask
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1 c += int'(out_update === 1'b1);
		end
		chk("update count", 32'h0, 32'(c));
	endtask
	// reference sweep: freq 100..190 step 10, level tracks freq minus 100
	task automatic steps(input int first, input int n, input bit rev);
		int ef, t0, k, w, sv;
		ef = first;
		t0 = -1;
		k = 0;
		sv = rev ? 190 : 100;
		while (k < n) begin
			w = 0;
			do begin
				@(posedge core_clk);
				#1 w++;
			end while (out_update !== 1'b1 && w < 200);
			if (w >= 200) begin
				chk("update seen", 32'h1, 32'h0);
				return;
			end
			// a wrap back to the start value at the end may pulse before the first real step
			if (k == 0 && ef != sv && out_freq === 32'(sv)) continue;
			chk("out_freq", 32'(ef), out_freq);
			chk("out_level", 32'(ef - 100), out_level);
			if (t0 >= 0) chk("dwell", 32'(DW), 32'(cyc - t0));
			t0 = cyc;
			k++;
			if (rev) ef = (ef == 100) ? 190 : ef - 10;
			else ef = (ef == 190) ? 100 : ef + 10;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(`REG_DWELL);
		chk("dwell reg", `DWELL_RESET, rd_val);
		rd(`REG_STEP_COUNT);
		chk("step_count reg", 32'(`STEP_COUNT_RESET), rd_val);
		rd(`REG_CTRL);
		chk("ctrl reg", 32'h90, rd_val);
		rd(4'hF);
		chk("unmapped", 32'h0, rd_val);
		$display("test reset_values done");
		for (int i = 0; i < 3; i++) begin
			a = 32'($random(seed)) & 32'h0000_FFFF;
			b = 32'($random(seed)) & 32'h0000_FFFF;
			if (i == 0 && a < b) {a, b} = {b, a};
			wr(`REG_START_F, a);
			wr(`REG_STOP_F, b);
			rd(`REG_SPAN_F);
			chk("span", b - a, rd_val);
			rd(`REG_CENTER_F);
			chk("center", (a + b) >> 1, rd_val);
		end
		wr(`REG_CENTER_F, 32'h2710);
		wr(`REG_SPAN_F, 32'h190);
		rd(`REG_START_F);
		chk("start", 32'h2648, rd_val);
		rd(`REG_STOP_F);
		chk("stop", 32'h27D8, rd_val);
		wr(`REG_OFFSET, 32'h7);
		rd(`REG_START_F);
		chk("start offset", 32'h264F, rd_val);
		rd(`REG_CENTER_F);
		chk("center offset", 32'h2717, rd_val);
		wr(`REG_OFFSET, 32'h0);
		$display("test range_arithmetic done");
		wr(`REG_START_F, 32'h64);
		wr(`REG_STOP_F, 32'hBE);
		wr(`REG_START_P, 32'h0);
		wr(`REG_STOP_P, 32'h5A);
		wr(`REG_STEP_COUNT, 32'hA);
		wr(`REG_DWELL, 32'(DW));
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_EXT_TOGGLE, sweep_seq_pkg::RUN_CONT, 1, 0, 0, 0));
		repeat (5) @(posedge core_clk);
		quiet(15);
		chk("start load", 32'h64, out_freq);
		chk("idle", 32'h0, 32'(running));
		i_trig.fire(6);
		wait_run(1'b1);
		steps(110, 12, 0);
		i_trig.fire(3);
		wait_run(1'b0);
		quiet(20);
		rd(`REG_STATUS);
		chk("status", 32'hA, rd_val);
		rd(`REG_CUR_F);
		chk("cur freq reg", 32'h64, rd_val);
		i_trig.fire(1);
		wait_run(1'b1);
		chk("restart", 32'h64, out_freq);
		steps(110, 2, 0);
		$display("test ext_toggle done");
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_SINGLE, sweep_seq_pkg::RUN_SINGLE, 1, 0, 0, 0));
		wait_run(1'b0);
		for (int r = 0; r < 2; r++) begin
			wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_SINGLE, sweep_seq_pkg::RUN_SINGLE, 1, r, 0, 0));
			wr(`REG_CMD, 32'h2);
			wait_run(1'b1);
			chk("single start", 32'h64, out_freq);
			steps(110, 9, 0);
			wait_run(1'b0);
			quiet(12);
			chk("end value", r ? 32'h64 : 32'hBE, out_freq);
		end
		$display("test single_retrace done");
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_AUTO, sweep_seq_pkg::RUN_CONT, 1, 0, 0, 0));
		wait_run(1'b1);
		steps(110, 3, 0);
		wr(`REG_CMD, 32'h1);
		repeat (2) @(posedge core_clk);
		#1 chk("sweep reset", 32'h64, out_freq);
		chk("still running", 32'h1, 32'(running));
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_AUTO, sweep_seq_pkg::RUN_CONT, 0, 0, 0, 0));
		wait_run(1'b0);
		quiet(20);
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_AUTO, sweep_seq_pkg::RUN_CONT, 1, 0, 1, 0));
		steps(180, 3, 1);
		// clock enable low must freeze the sweep mid-dwell
		@(posedge core_clk) clk_en <= 1'b0;
		quiet(10);
		chk("frozen freq", 32'hA0, out_freq);
		chk("frozen run", 32'h1, 32'(running));
		@(posedge core_clk) clk_en <= 1'b1;
		wr(`REG_CTRL, 32'h0);
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_AUTO, sweep_seq_pkg::RUN_STEP, 1, 0, 0, 0));
		quiet(12);
		chk("step start", 32'h64, out_freq);
		for (int i = 1; i < 3; i++) begin
			wr(`REG_CMD, 32'h4);
			repeat (3) @(posedge core_clk);
			#1 chk("step value", 32'(100 + 10 * i), out_freq);
		end
		$display("test auto_modes done");
		wr(`REG_CTRL, 32'h0);
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_MANUAL, sweep_seq_pkg::RUN_CONT, 0, 0, 0, 0));
		rd(`REG_CTRL);
		chk("mode local", 32'h0, {29'h0, rd_val[3:1]});
		wr(`REG_CTRL, ctl(sweep_seq_pkg::TRIG_MANUAL, sweep_seq_pkg::RUN_CONT, 1, 0, 0, 1));
		for (int i = 0; i < 3; i++) begin
			a = 32'(100 + ($unsigned($random(seed)) % 91));
			wr(`REG_MANUAL, a);
			repeat (2) @(posedge core_clk);
			#1 chk("manual value", a, out_freq);
		end
		$display("test manual done");
		close_out();
	end
endmodule
